// ---- pwm3_pkg.sv ----
// Constants shared by the three-phase PWM timer.
// Assumes a 32-bit classic Wishbone slave and one system clock.
package pwm3_pkg;
    localparam int CNT_W = 18; // Counter and compare width
    localparam int DT_W = 12; // Dead time counter width
    localparam int NSLOT = 12; // Output compare slots
    // Register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_PERIOD = 8'h08;
    localparam logic [7:0] A_DUTY_U = 8'h0C;
    localparam logic [7:0] A_DUTY_V = 8'h10;
    localparam logic [7:0] A_DUTY_W = 8'h14;
    localparam logic [7:0] A_DEAD_PN = 8'h18;
    localparam logic [7:0] A_DEAD_NP = 8'h1C;
    localparam logic [7:0] A_PAT_FIRST = 8'h20;
    localparam logic [7:0] A_PAT_SECOND = 8'h24;
    localparam logic [7:0] A_ADC_CMP = 8'h28;
    localparam logic [7:0] A_HIZ_EN = 8'h2C;
    localparam logic [7:0] A_SLOT0 = 8'h40;
    localparam logic [7:0] A_SLOT11 = 8'h6C;
    // Control fields
    localparam int C_RUN = 0;
    localparam int C_BLOCK = 1;
    localparam int C_PEAK_EN = 2;
    localparam int C_TROUGH_EN = 3;
    localparam int C_METH = 4; // Two bits: method of commutation
    // Status and Hi-Z source fields
    localparam int S_HIZ = 0;
    localparam int H_ESTOP = 0;
    localparam int H_TERR = 3;
    localparam int H_EOUT = 5;
    // Commutation methods
    localparam logic [1:0] M_SW = 2'h0;
    localparam logic [1:0] M_PAT = 2'h1;
    localparam logic [1:0] M_TRIG = 2'h2;
    // Reset values
    localparam logic [CNT_W-1:0] RST_PERIOD = 18'h3FFFE;
    localparam logic [DT_W-1:0] RST_DEAD = 12'h010;
    localparam logic [7:0] RST_HIZ_EN = 8'h01;
    // Count clock figures: 12.5 ns per count at 80 MHz
    localparam int COUNT_CLK_MHZ = 80;
    localparam int RES_PS = 12500;
    localparam int SYS_CLK_MHZ = 20;
    localparam int SYS_PER_PS = 1000000 / SYS_CLK_MHZ;
endpackage

// ---- three_phase_timer.sv ----
// Three-phase PWM timer with dead time, block commutation and Hi-Z stop.
// Assumes a classic Wishbone master on sys_clk and asynchronous pins.
`timescale 1ns/10ps

// Overview of operation
// - 18-bit counter, one count per clock in block mode, two in triangle mode
// - Separate dead times for each transition
// - Forced stop puts six outputs Hi-Z
// - Compare match pulses ADC trigger automatically
// - Triangle counts by two; compare LSB adds pulse
// - Triangle period from carrier period register
// - Phase duty copies into slots 0,1,4,5,8,9
// - Peak interrupt only when enabled
// - Trough interrupt only when enabled
// - Block mode: period register, twelve compare slots
// - Block outputs gated: software, pattern, trigger
// - Block mode peak coincides with period match
// - Illegal Hall pattern raises warning interrupt in block mode
// - Pattern sense fed from Hall pins
// - Inputs active low; all-high means invalid
// - Abnormal condition forces Hi-Z in hardware
// - Hi-Z enable bit 0 selects emergency stop
// - Bit 5 error output, bit 3 timer error
module three_phase_timer (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic hall_u_input,
    input wire logic hall_v_input,
    input wire logic hall_w_input,
    input wire logic emergency_stop_input_n,
    input wire logic error_output_source_n,
    output logic [5:0] phase_outputs,
    output logic [5:0] phase_outputs_oe,
    output logic adc_trigger,
    output logic carrier_peak_interrupt,
    output logic carrier_trough_interrupt,
    output logic period_match_interrupt,
    output logic pattern_warning_interrupt,
    output logic timer_error_interrupt
);
    typedef logic [pwm3_pkg::CNT_W-1:0] cnt_t;
    // Whole state of the block
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [7:0] ctrl;
        cnt_t period;
        cnt_t adc_cmp;
        logic [pwm3_pkg::DT_W-1:0] dead_pn;
        logic [pwm3_pkg::DT_W-1:0] dead_np;
        logic [31:0] pat_first;
        logic [31:0] pat_second;
        logic [7:0] hiz_en;
        logic [pwm3_pkg::NSLOT-1:0][pwm3_pkg::CNT_W-1:0] slot;
        cnt_t cnt;
        logic down;
        logic [4:0] s1, s2, s3, f; // Pin synchroniser chain and filtered value
        logic illegal;
        logic [5:0] trig_en;
        logic [2:0][1:0] tgt;
        logic [2:0][pwm3_pkg::DT_W-1:0] dtc;
        logic [5:0] out;
        logic hiz;
        logic peak, trough, prd, warn, terr, adc;
    } state_t;
    state_t q, d;
    // Assertions at the end sample on sys_clk and rest during reset
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Byte-enable merge of a write
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        return r;
    endfunction
    // Output enables for one Hall code; codes 0 and 7 give none
    function automatic logic [5:0] pat_lookup(input logic [2:0] c, input logic [31:0] a,
                                              input logic [31:0] b);
        case (c)
            3'h1: return a[5:0];
            3'h2: return a[13:8];
            3'h3: return a[21:16];
            3'h4: return b[5:0];
            3'h5: return b[13:8];
            3'h6: return b[21:16];
            default: return 6'h00;
        endcase
    endfunction
    // Half-compare with an extra count when counting down and the compare LSB is set
    function automatic logic tri_on(input cnt_t c, input cnt_t cmp, input logic dn);
        logic [pwm3_pkg::CNT_W-1:0] thr;
        thr = {1'b0, cmp[pwm3_pkg::CNT_W-1:1]} + cnt_t'(dn & cmp[0]);
        return {1'b0, c[pwm3_pkg::CNT_W-1:1]} < thr;
    endfunction
    logic wr, rd_ok;
    logic [2:0] hall_code;
    logic [5:0] en;
    logic [2:0][1:0] want;
    logic ev_top, ev_bot;
    logic hiz_req, hiz_clr;
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !q.ack;
    assign hiz_clr = wr && wb_adr_i == pwm3_pkg::A_STAT && wb_sel_i[0]
                     && wb_dat_i[pwm3_pkg::S_HIZ];
    // Next-state logic
    always_comb begin
        d = q;
        rd_ok = 1'b1;
        // Hall code from active-low pins; all-high reads as code zero
        hall_code = ~q.f[2:0];
        // Bus slave: one wait state, ack for one cycle
        d.ack = wb_cyc_i && wb_stb_i && !q.ack;
        d.rdat = 32'h0000_0000;
        if (wb_adr_i == pwm3_pkg::A_CTRL) begin
            d.rdat = {24'h000000, q.ctrl};
        end else if (wb_adr_i == pwm3_pkg::A_STAT) begin
            d.rdat = {2'h0, q.f[2:0], q.down, 4'h0, hall_code, q.hiz, 18'h00000} | 32'(q.cnt);
        end else if (wb_adr_i == pwm3_pkg::A_PERIOD) begin
            d.rdat = 32'(q.period);
        end else if (wb_adr_i == pwm3_pkg::A_DEAD_PN) begin
            d.rdat = 32'(q.dead_pn);
        end else if (wb_adr_i == pwm3_pkg::A_DEAD_NP) begin
            d.rdat = 32'(q.dead_np);
        end else if (wb_adr_i == pwm3_pkg::A_PAT_FIRST) begin
            d.rdat = q.pat_first;
        end else if (wb_adr_i == pwm3_pkg::A_PAT_SECOND) begin
            d.rdat = q.pat_second;
        end else if (wb_adr_i == pwm3_pkg::A_ADC_CMP) begin
            d.rdat = 32'(q.adc_cmp);
        end else if (wb_adr_i == pwm3_pkg::A_HIZ_EN) begin
            d.rdat = {24'h000000, q.hiz_en};
        end else if (wb_adr_i >= pwm3_pkg::A_SLOT0 && wb_adr_i <= pwm3_pkg::A_SLOT11
                     && wb_adr_i[1:0] == 2'h0) begin
            d.rdat = 32'(q.slot[wb_adr_i[5:2]]);
        end else begin
            // Unmapped and duty registers read zero
            rd_ok = 1'b0;
        end
        if (wr) begin
            if (wb_adr_i == pwm3_pkg::A_CTRL) begin
                d.ctrl = 8'(merge(32'(q.ctrl), wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == pwm3_pkg::A_PERIOD) begin
                d.period = cnt_t'(merge(32'(q.period), wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == pwm3_pkg::A_DUTY_U) begin
                d.slot[0] = cnt_t'(merge(32'(q.slot[0]), wb_dat_i, wb_sel_i));
                d.slot[1] = d.slot[0];
            end else if (wb_adr_i == pwm3_pkg::A_DUTY_V) begin
                d.slot[4] = cnt_t'(merge(32'(q.slot[4]), wb_dat_i, wb_sel_i));
                d.slot[5] = d.slot[4];
            end else if (wb_adr_i == pwm3_pkg::A_DUTY_W) begin
                d.slot[8] = cnt_t'(merge(32'(q.slot[8]), wb_dat_i, wb_sel_i));
                d.slot[9] = d.slot[8];
            end else if (wb_adr_i == pwm3_pkg::A_DEAD_PN) begin
                d.dead_pn = 12'(merge(32'(q.dead_pn), wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == pwm3_pkg::A_DEAD_NP) begin
                d.dead_np = 12'(merge(32'(q.dead_np), wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == pwm3_pkg::A_PAT_FIRST) begin
                d.pat_first = merge(q.pat_first, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == pwm3_pkg::A_PAT_SECOND) begin
                d.pat_second = merge(q.pat_second, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == pwm3_pkg::A_ADC_CMP) begin
                d.adc_cmp = cnt_t'(merge(32'(q.adc_cmp), wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == pwm3_pkg::A_HIZ_EN) begin
                d.hiz_en = 8'(merge(32'(q.hiz_en), wb_dat_i, wb_sel_i));
            end else if (rd_ok && wb_adr_i >= pwm3_pkg::A_SLOT0) begin
                d.slot[wb_adr_i[5:2]] =
                    cnt_t'(merge(32'(q.slot[wb_adr_i[5:2]]), wb_dat_i, wb_sel_i));
            end
        end
        // Pin synchronisers; a change counts once stages two and three agree
        d.s1 = {error_output_source_n, emergency_stop_input_n,
                hall_w_input, hall_v_input, hall_u_input};
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < 5; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.f[i] = q.s3[i];
            end
        end
        // Counter; events are pulses of one cycle
        ev_top = 1'b0;
        ev_bot = 1'b0;
        if (!q.ctrl[pwm3_pkg::C_RUN]) begin
            d.cnt = '0;
            d.down = 1'b0;
        end else if (!q.ctrl[pwm3_pkg::C_BLOCK]) begin
            // Triangle carrier stepping by two, even counts only
            if (!q.down) begin
                if (q.cnt + 18'h00002 >= {q.period[17:1], 1'b0}) begin
                    d.cnt = {q.period[17:1], 1'b0};
                    d.down = 1'b1;
                    ev_top = 1'b1;
                end else begin
                    d.cnt = {q.cnt[17:1], 1'b0} + 18'h00002;
                end
            end else begin
                if (q.cnt <= 18'h00002) begin
                    d.cnt = '0;
                    d.down = 1'b0;
                    ev_bot = 1'b1;
                end else begin
                    d.cnt = {q.cnt[17:1], 1'b0} - 18'h00002;
                end
            end
        end else begin
            // Sawtooth for block commutation
            d.down = 1'b0;
            if (q.cnt >= q.period) begin
                d.cnt = '0;
                ev_top = 1'b1;
            end else begin
                d.cnt = q.cnt + 18'h00001;
            end
        end
        d.peak = ev_top && q.ctrl[pwm3_pkg::C_PEAK_EN];
        d.trough = ev_bot && q.ctrl[pwm3_pkg::C_TROUGH_EN];
        d.prd = ev_top && q.ctrl[pwm3_pkg::C_BLOCK];
        d.adc = q.ctrl[pwm3_pkg::C_RUN] && q.cnt == q.adc_cmp;
        // Illegal codes warn once on entry in block mode
        d.illegal = hall_code == 3'h0 || hall_code == 3'h7;
        d.warn = d.illegal && !q.illegal && q.ctrl[pwm3_pkg::C_BLOCK];
        d.terr = d.warn;
        if (q.ctrl[pwm3_pkg::C_BLOCK] && ev_top) begin
            d.trig_en = pat_lookup(hall_code, q.pat_first, q.pat_second);
        end
        // Commutation gating by method
        case (q.ctrl[pwm3_pkg::C_METH +: 2])
            pwm3_pkg::M_SW: en = q.pat_first[5:0];
            pwm3_pkg::M_PAT: en = pat_lookup(hall_code, q.pat_first, q.pat_second);
            pwm3_pkg::M_TRIG: en = q.trig_en;
            default: en = 6'h00;
        endcase
        // Wanted high/low per phase
        for (int p = 0; p < 3; p++) begin
            if (!q.ctrl[pwm3_pkg::C_RUN]) begin
                want[p] = 2'h0;
            end else if (!q.ctrl[pwm3_pkg::C_BLOCK]) begin
                // Complementary pair from the up or down slot
                want[p][0] = q.down ? tri_on(q.cnt, q.slot[4*p+1], 1'b1)
                                    : tri_on(q.cnt, q.slot[4*p], 1'b0);
                want[p][1] = !want[p][0];
            end else begin
                for (int k = 0; k < 2; k++) begin
                    want[p][k] = en[2*p+k] && q.cnt >= q.slot[4*p+2*k]
                                 && q.cnt < q.slot[4*p+2*k+1];
                end
            end
        end
        // Dead time: both sides off, then the new state
        for (int p = 0; p < 3; p++) begin
            if (want[p] != q.tgt[p]) begin
                d.tgt[p] = want[p];
                d.dtc[p] = want[p][0] ? q.dead_np : q.dead_pn;
                d.out[2*p +: 2] = 2'h0;
            end else if (q.dtc[p] != '0) begin
                d.dtc[p] = q.dtc[p] - 12'h001;
            end else begin
                d.out[2*p +: 2] = q.tgt[p];
            end
        end
        // Hi-Z latch; set wins over a clear in the same cycle
        hiz_req = (q.hiz_en[pwm3_pkg::H_ESTOP] && !q.f[3])
                  || (q.hiz_en[pwm3_pkg::H_EOUT] && !q.f[4])
                  || (q.hiz_en[pwm3_pkg::H_TERR] && q.terr);
        if (hiz_req) begin
            d.hiz = 1'b1;
        end else if (hiz_clr) begin
            d.hiz = 1'b0;
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q <= '0;
            q.period <= pwm3_pkg::RST_PERIOD;
            q.dead_pn <= pwm3_pkg::RST_DEAD;
            q.dead_np <= pwm3_pkg::RST_DEAD;
            q.hiz_en <= pwm3_pkg::RST_HIZ_EN;
            q.s1 <= 5'h1F;
            q.s2 <= 5'h1F;
            q.s3 <= 5'h1F;
            q.f <= 5'h1F;
            q.illegal <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdat;
    assign phase_outputs = q.out;
    assign phase_outputs_oe = q.hiz ? 6'h00 : 6'h3F;
    assign adc_trigger = q.adc;
    assign carrier_peak_interrupt = q.peak;
    assign carrier_trough_interrupt = q.trough;
    assign period_match_interrupt = q.prd;
    assign pattern_warning_interrupt = q.warn;
    assign timer_error_interrupt = q.terr;

    property p_even;
        !q.ctrl[pwm3_pkg::C_BLOCK] ##1 !q.ctrl[pwm3_pkg::C_BLOCK] |-> !q.cnt[0];
    endproperty
    a_even: assert property (p_even) else $error("odd count in triangle mode");
    property p_hiz_off;
        q.hiz |-> phase_outputs_oe == 6'h00;
    endproperty
    a_hiz_off: assert property (p_hiz_off) else $error("outputs driven in Hi-Z");
    property p_estop;
        q.hiz_en[pwm3_pkg::H_ESTOP] && !q.f[3] |=> q.hiz ##0 phase_outputs_oe == 6'h00;
    endproperty
    a_estop: assert property (p_estop) else $error("stop did not force Hi-Z");
    property p_hold;
        q.hiz && !hiz_clr |=> q.hiz;
    endproperty
    a_hold: assert property (p_hold) else $error("Hi-Z released without clear");
    property p_peak;
        carrier_peak_interrupt |-> $past(q.ctrl[pwm3_pkg::C_PEAK_EN]);
    endproperty
    a_peak: assert property (p_peak) else $error("peak raised while disabled");
    property p_trough;
        carrier_trough_interrupt |-> $past(q.ctrl[pwm3_pkg::C_TROUGH_EN]);
    endproperty
    a_trough: assert property (p_trough) else $error("trough raised while disabled");
    property p_blk_peak;
        period_match_interrupt && $past(q.ctrl[pwm3_pkg::C_PEAK_EN]) |-> carrier_peak_interrupt;
    endproperty
    a_blk_peak: assert property (p_blk_peak) else $error("peak not with period");
    property p_duty;
        wr && wb_adr_i == pwm3_pkg::A_DUTY_V && wb_sel_i == 4'hF
        |=> q.slot[4] == $past(wb_dat_i[17:0]) && q.slot[5] == q.slot[4];
    endproperty
    a_duty: assert property (p_duty) else $error("duty not copied");
    property p_overlap;
        !(phase_outputs[0] && phase_outputs[1]) && !(phase_outputs[2] && phase_outputs[3])
        && !(phase_outputs[4] && phase_outputs[5]);
    endproperty
    a_overlap: assert property (p_overlap) else $error("pair overlap");
    property p_warn;
        q.ctrl[pwm3_pkg::C_BLOCK] && !q.illegal && q.f[2:0] == 3'h7
        |=> pattern_warning_interrupt ##0 timer_error_interrupt;
    endproperty
    a_warn: assert property (p_warn) else $error("illegal pattern missed");
    property p_adc;
        q.ctrl[pwm3_pkg::C_RUN] && q.cnt == q.adc_cmp |=> adc_trigger;
    endproperty
    a_adc: assert property (p_adc) else $error("ADC trigger missed");
endmodule

// ---- gate_predriver_model.sv ----
// Behavioural gate pre-driver stage fed by the six phase outputs.
// Assumes the timer's pins and enables are sampled on sys_clk.
`timescale 1ns/10ps
module gate_predriver_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [5:0] gate_in,
    input wire logic [5:0] gate_oe,
    input wire logic fault_req,
    output logic fault_n,
    output logic shoot_r
);
    logic [5:0] gate_lvl; // Level seen at the gate inputs
    logic leg_both; // Both switches of one leg on

    // Released pins fall to the pre-driver's pull-down
    assign gate_lvl = gate_in & gate_oe;
    // Combined board fault drives the active-low stop line
    assign fault_n = ~fault_req;
    // Any leg with high and low side on at once
    assign leg_both = (gate_lvl[0] & gate_lvl[1]) | (gate_lvl[2] & gate_lvl[3]) |
        (gate_lvl[4] & gate_lvl[5]);

    // Sticky shoot-through flag
    always @(posedge sys_clk) begin
        if (rst) begin
            shoot_r <= 1'b0;
        end else if (leg_both) begin
            shoot_r <= 1'b1;
        end
    end
endmodule

// ---- three_phase_timer_tb.sv ----
// Self-checking bench for the three-phase timer over its Wishbone port.
// Assumes the timer package and the gate pre-driver model come first.
`timescale 1ns/10ps
module three_phase_timer_tb;
    localparam int LIMIT = 5000; // Cycle ceiling for the whole run
    logic sys_clk = 1'b0; // System clock
    logic rst = 1'b1; // Synchronous reset
    logic cyc = 1'b0; // Bus cycle
    logic stb = 1'b0; // Bus strobe
    logic we = 1'b0; // Bus direction
    logic [7:0] adr = 8'h00; // Bus address
    logic [31:0] wdat = 32'h0; // Write data
    logic [31:0] rdat; // Read data
    logic [31:0] r; // Last value read
    logic ack; // Bus answer
    logic hu = 1'b1; // Hall pins, idle high
    logic hv = 1'b1;
    logic hw = 1'b1;
    logic err_n = 1'b1; // Error output pin
    logic fault_req = 1'b0; // Board fault request
    logic stop_n; // Stop line from the pre-driver
    logic shoot; // Shoot-through flag
    logic [5:0] po; // Phase outputs
    logic [5:0] oe; // Phase output enables
    logic adc, pk, tr, pm, wn, te;
    int fail_count = 0;
    int checks = 0;
    int cyc_n = 0; // Free cycle count
    int cnt[6] = '{0, 0, 0, 0, 0, 0}; // Peak, trough, adc, warn, mismatch, U+ high
    int d[6]; // Counts over the last window
    int pk_at = 0; // Cycle of last peak
    int pk_gap = 0; // Cycles between peaks
    int gap = 0; // Cycles with both U sides off
    int gap_hi = 0; // Gap before U+ rose
    int gap_lo = 0; // Gap before U- rose

    three_phase_timer dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .hall_u_input(hu), .hall_v_input(hv), .hall_w_input(hw),
        .emergency_stop_input_n(stop_n), .error_output_source_n(err_n),
        .phase_outputs(po), .phase_outputs_oe(oe), .adc_trigger(adc),
        .carrier_peak_interrupt(pk), .carrier_trough_interrupt(tr),
        .period_match_interrupt(pm), .pattern_warning_interrupt(wn),
        .timer_error_interrupt(te));
    gate_predriver_model gdrv (.sys_clk(sys_clk), .rst(rst), .gate_in(po), .gate_oe(oe),
        .fault_req(fault_req), .fault_n(stop_n), .shoot_r(shoot));

    // Clock generator
    always #25 sys_clk = ~sys_clk;

    // Event counters, dead gap measure and watchdog
    always @(posedge sys_clk) begin
        cyc_n <= cyc_n + 1;
        if (pk === 1'b1) begin
            cnt[0] <= cnt[0] + 1;
            pk_gap <= cyc_n - pk_at;
            pk_at <= cyc_n;
        end
        if (tr === 1'b1) cnt[1] <= cnt[1] + 1;
        if (adc === 1'b1) cnt[2] <= cnt[2] + 1;
        if (wn === 1'b1) cnt[3] <= cnt[3] + 1;
        if (pk !== pm || wn !== te) cnt[4] <= cnt[4] + 1;
        if (po[0] === 1'b1) cnt[5] <= cnt[5] + 1;
        if (po[1:0] === 2'b00) begin
            gap <= gap + 1;
        end else begin
            if (gap != 0 && po[0] === 1'b1) gap_hi <= gap;
            if (gap != 0 && po[1] === 1'b1) gap_lo <= gap;
            gap <= 0;
        end
        if (cyc_n == LIMIT) begin
            fail_count++;
            report_and_stop();
        end
    end

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic Wishbone cycle, held until ack is sampled
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= v;
        @(posedge sys_clk);
        while (ack !== 1'b1) @(posedge sys_clk);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        xfer(1'b1, a, v);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(r, e);
    endtask

    // Wait n cycles and keep the event counts seen meanwhile
    task automatic run_win(input int n);
        int s[6];
        s = cnt;
        repeat (n) @(posedge sys_clk);
        for (int i = 0; i < 6; i++) d[i] = cnt[i] - s[i];
    endtask

    // Drop one stop source for ten cycles, then release it
    task automatic stop_pulse(input logic use_err);
        err_n <= ~use_err;
        fault_req <= ~use_err;
        repeat (10) @(posedge sys_clk);
        err_n <= 1'b1;
        fault_req <= 1'b0;
        repeat (10) @(posedge sys_clk);
    endtask

    task automatic report_and_stop();
        if (fail_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rchk(pwm3_pkg::A_CTRL, 32'h0);
        rchk(pwm3_pkg::A_PERIOD, 32'(pwm3_pkg::RST_PERIOD));
        rchk(pwm3_pkg::A_DEAD_PN, 32'(pwm3_pkg::RST_DEAD));
        rchk(pwm3_pkg::A_DEAD_NP, 32'(pwm3_pkg::RST_DEAD));
        rchk(pwm3_pkg::A_HIZ_EN, 32'(pwm3_pkg::RST_HIZ_EN));
        rchk(8'h30, 32'h0);
        // Phase duty lands in both slots of its phase
        for (int i = 0; i < 3; i++) begin
            wr(pwm3_pkg::A_DUTY_U + 8'(4 * i), 32'h10 + 32'(8 * i));
            rchk(pwm3_pkg::A_DUTY_U + 8'(4 * i), 32'h0);
            rchk(pwm3_pkg::A_SLOT0 + 8'(16 * i), 32'h10 + 32'(8 * i));
            rchk(pwm3_pkg::A_SLOT0 + 8'(16 * i + 4), 32'h10 + 32'(8 * i));
        end
        // Triangle carrier, peak interrupt only
        wr(pwm3_pkg::A_DEAD_PN, 32'h3);
        wr(pwm3_pkg::A_DEAD_NP, 32'h6);
        wr(pwm3_pkg::A_PERIOD, 32'h20);
        wr(pwm3_pkg::A_ADC_CMP, 32'h10);
        wr(pwm3_pkg::A_CTRL, 32'h5);
        run_win(320);
        chk(32'(pk_gap), 32'h20);
        chk(32'(d[1]), 32'h0);
        chk(32'(d[2] >= 18), 32'h1);
        chk(32'(gap_hi), 32'h7);
        chk(32'(gap_lo), 32'h4);
        chk(32'(shoot), 32'h0);
        xfer(1'b0, pwm3_pkg::A_STAT, 32'h0);
        chk(32'(r[0]), 32'h0);
        chk(32'(r[17:0] <= 18'h20), 32'h1);
        // Trough interrupt only, then halted
        wr(pwm3_pkg::A_CTRL, 32'h9);
        run_win(320);
        chk(32'(d[0]), 32'h0);
        chk(32'(d[1] >= 9), 32'h1);
        wr(pwm3_pkg::A_CTRL, 32'h0);
        run_win(100);
        chk(32'(d[2]), 32'h0);
        // Forced stop and its sources
        stop_pulse(1'b0);
        chk(32'(oe), 32'h0);
        xfer(1'b0, pwm3_pkg::A_STAT, 32'h0);
        chk(32'(r[18]), 32'h1);
        wr(pwm3_pkg::A_STAT, 32'h1);
        chk(32'(oe), 32'h3F);
        wr(pwm3_pkg::A_HIZ_EN, 32'h0);
        stop_pulse(1'b0);
        chk(32'(oe), 32'h3F);
        wr(pwm3_pkg::A_HIZ_EN, 32'h20);
        stop_pulse(1'b1);
        chk(32'(oe), 32'h0);
        wr(pwm3_pkg::A_STAT, 32'h1);
        // Block commutation, every method
        hu <= 1'b0;
        wr(pwm3_pkg::A_HIZ_EN, 32'h8);
        wr(pwm3_pkg::A_PAT_FIRST, 32'h1);
        wr(pwm3_pkg::A_PAT_SECOND, 32'h0);
        wr(pwm3_pkg::A_SLOT0, 32'h0);
        wr(pwm3_pkg::A_SLOT0 + 8'h04, 32'h10);
        for (int m = 2; m >= 0; m--) begin
            wr(pwm3_pkg::A_CTRL, 32'h7 | 32'(m << 4));
            run_win(200);
            chk(32'(d[5] > 0), 32'h1);
            chk(32'(d[4]), 32'h0);
        end
        chk(32'(pk_gap), 32'h21);
        xfer(1'b0, pwm3_pkg::A_STAT, 32'h0);
        chk(32'(r[21:19]), 32'h1);
        chk(32'(r[29:27]), 32'h6);
        wr(pwm3_pkg::A_PAT_FIRST, 32'h0);
        repeat (10) @(posedge sys_clk);
        run_win(100);
        chk(32'(d[5]), 32'h0);
        hu <= 1'b1;
        run_win(20);
        chk(32'(d[3]), 32'h1);
        chk(32'(oe), 32'h0);
        chk(32'(d[4]), 32'h0);
        report_and_stop();
    end
endmodule
